// ---- src/eeprom_port.sv ----
// Serial command port of a 1024 x 16 word store with self-timed writes.
// Assumes link pins are asynchronous to core_clk and sampled here; APB is on core_clk.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module eeprom_port
    import eeprom_port_pkg::*;
#(
    parameter int unsigned PROG_LEN_DEFAULT = PROG_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link pins
    input  wire logic        select_n,
    input  wire logic        shift_clock_in,
    input  wire logic        serial_in_pin,
    input  wire logic        write_abort,
    output logic             serial_out,
    output logic             serial_out_oe,
    output logic             prog_ready
);
    logic                 cs_n_s;
    logic                 sck_s;
    logic                 data_in_s;
    logic                 abort_s;
    logic                 cs_n_d;
    logic                 sck_d;
    link_state_t          state;
    logic [CNT_W-1:0]     bit_cnt;
    logic [FRAME_W-1:0]   shreg;
    logic [ADDR_W-1:0]    rd_addr;
    logic [WORD_W-1:0]    out_word;
    logic [3:0]           out_cnt;
    logic                 wel;
    logic                 busy;
    logic [ADDR_W-1:0]    prog_addr;
    logic [WORD_W-1:0]    prog_data;
    logic [PLEN_W-1:0]    prog_cnt;
    logic [PLEN_W-1:0]    prog_len;
    logic [ADDR_W-1:0]    peek_addr;
    logic [WORD_W-1:0]    mem [WORDS];

    pin_sync #(.RESET_VAL(1'b1)) u_sync_cs (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin      (select_n),
        .level    (cs_n_s)
    );
    pin_sync #(.RESET_VAL(1'b1)) u_sync_sck (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin      (shift_clock_in),
        .level    (sck_s)
    );
    pin_sync #(.RESET_VAL(1'b0)) u_sync_data (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin      (serial_in_pin),
        .level    (data_in_s)
    );
    pin_sync #(.RESET_VAL(1'b0)) u_sync_abort (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin      (write_abort),
        .level    (abort_s)
    );

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cs_n_d <= 1'b1;
            sck_d  <= 1'b1;
        end else begin
            cs_n_d <= cs_n_s;
            sck_d  <= sck_s;
        end
    end

    // Edge and decode terms
    wire                cs_fall    = cs_n_d & ~cs_n_s;
    wire                cs_rise    = ~cs_n_d & cs_n_s;
    wire                sck_rise   = ~sck_d & sck_s;
    wire                sck_fall   = sck_d & ~sck_s;
    wire [FRAME_W-1:0]  next_shreg = {shreg[FRAME_W-2:0], data_in_s};
    wire [CNT_W-1:0]    next_cnt   = bit_cnt + 6'h01;
    wire                take_bit   = (state == LINK_RECV) && sck_rise && !cs_n_s;
    wire                hdr_done   = take_bit && (next_cnt == HDR_BITS);
    wire                frame_done = take_bit && (next_cnt == FRAME_BITS);
    wire [7:0]          opcode     = next_shreg[15:8];
    // Whole frame including the bit taken now; shreg alone is one bit short
    wire [7:0]          op_stored  = next_shreg[31:24];
    wire                is_read    = (opcode[7:2] == OP_READ_HI);
    wire                is_write   = (opcode[7:2] == OP_WRITE_HI);
    wire                wr_frame   = (op_stored[7:2] == OP_WRITE_HI);
    wire [ADDR_W-1:0]   hdr_addr   = {opcode[1:0], next_shreg[7:0]};
    wire                prog_start = frame_done && wr_frame && wel && !abort_s && !busy;
    wire                out_step   = (state == LINK_READ) && sck_fall && !cs_n_s;
    wire                word_end   = out_step && serial_out_oe && (out_cnt == 4'hf);
    wire [ADDR_W-1:0]   next_addr  = rd_addr + 10'h001;
    wire [PLEN_W-1:0]   next_pcnt  = prog_cnt + 24'h000001;
    wire                prog_end   = busy && (next_pcnt >= prog_len);

    // Link frame sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state         <= LINK_IDLE;
            bit_cnt       <= '0;
            shreg         <= '0;
            rd_addr       <= '0;
            out_word      <= '0;
            out_cnt       <= '0;
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
            wel           <= 1'b0;
        end else if (cs_rise || cs_n_s) begin
            state         <= LINK_IDLE;
            serial_out_oe <= 1'b0;
        end else begin
            unique case (state)
                LINK_IDLE: begin
                    if (cs_fall && sck_s) begin
                        state   <= busy ? LINK_IGNORE : LINK_RECV;
                        bit_cnt <= '0;
                    end else if (cs_fall) begin
                        state         <= LINK_STATUS;
                        serial_out    <= ~busy;
                        serial_out_oe <= 1'b1;
                    end
                end
                LINK_STATUS: begin
                    serial_out <= ~busy;
                    if (sck_rise && data_in_s) begin
                        state         <= busy ? LINK_IGNORE : LINK_RECV;
                        serial_out_oe <= 1'b0;
                        shreg         <= next_shreg;
                        bit_cnt       <= 6'h01;
                    end
                end
                LINK_RECV: begin
                    if (take_bit) begin
                        shreg   <= next_shreg;
                        bit_cnt <= next_cnt;
                    end
                    if (hdr_done) begin
                        if (is_read) begin
                            state    <= LINK_READ;
                            rd_addr  <= hdr_addr;
                            out_word <= mem[hdr_addr];
                            out_cnt  <= '0;
                        end else if (!is_write) begin
                            state <= LINK_IGNORE;
                            if (opcode == OP_ENABLE) begin
                                wel <= 1'b1;
                            end else if (opcode == OP_DISABLE) begin
                                wel <= 1'b0;
                            end
                        end
                    end
                    if (frame_done) begin
                        state <= LINK_IGNORE;
                    end
                end
                LINK_READ: begin
                    if (out_step) begin
                        serial_out    <= out_word[WORD_W-1];
                        serial_out_oe <= 1'b1;
                        out_cnt       <= out_cnt + 4'h1;
                        out_word      <= {out_word[WORD_W-2:0], 1'b0};
                    end
                    if (word_end) begin
                        rd_addr  <= next_addr;
                        out_word <= mem[next_addr];
                    end
                end
                LINK_IGNORE: begin
                end
                default: begin
                    state <= LINK_IDLE;
                end
            endcase
        end
    end

    // Self-timed programming; runs from core_clk only, ignores select
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy      <= 1'b0;
            prog_cnt  <= '0;
            prog_addr <= '0;
            prog_data <= '0;
        end else if (prog_start) begin
            busy      <= 1'b1;
            prog_cnt  <= '0;
            prog_addr <= {next_shreg[25:24], next_shreg[23:16]};
            prog_data <= next_shreg[WORD_W-1:0];
        end else if (busy && abort_s) begin
            busy <= 1'b0;
        end else if (busy) begin
            prog_cnt <= next_pcnt;
            if (prog_end) begin
                busy <= 1'b0;
            end
        end
    end

    // Array write at the end of a completed programming time
    always_ff @(posedge core_clk) begin
        if (prog_end && !abort_s) begin
            mem[prog_addr] <= prog_data;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prog_ready <= 1'b1;
        end else begin
            prog_ready <= ~busy;
        end
    end

    // APB register window
    wire        apb_wr    = psel && penable && pwrite;
    wire        hit_stat  = (paddr == REG_STATUS);
    wire        hit_len   = (paddr == REG_PROG_LEN);
    wire        hit_peeka = (paddr == REG_PEEK_ADDR);
    wire        hit_peekd = (paddr == REG_PEEK_DATA);
    wire        mapped    = hit_stat | hit_len | hit_peeka | hit_peekd;
    wire [31:0] stat_word = {25'h0000000, state, 1'b0, serial_out_oe, wel, busy};
    wire [31:0] rd_mux    = hit_stat  ? stat_word :
                            hit_len   ? {8'h00, prog_len} :
                            hit_peeka ? {22'h000000, peek_addr} :
                            hit_peekd ? {16'h0000, mem[peek_addr]} : 32'h00000000;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = (psel && penable && !pwrite) ? rd_mux : 32'h00000000;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prog_len  <= PLEN_W'(PROG_LEN_DEFAULT);
            peek_addr <= '0;
        end else if (apb_wr && hit_len) begin
            prog_len <= pwdata[PLEN_W-1:0];
        end else if (apb_wr && hit_peeka) begin
            peek_addr <= pwdata[ADDR_W-1:0];
        end
    end

    // Checks
    ready_pin_a: assert property (@(posedge core_clk) disable iff (!nrst)
        prog_ready == !$past(busy)) else $error("ready pin does not follow busy");
    oe_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst)
        serial_out_oe |-> (state == LINK_STATUS) || (state == LINK_READ))
        else $error("serial output driven outside read or status");
    bit_take_a: assert property (@(posedge core_clk) disable iff (!nrst)
        take_bit && !frame_done && !hdr_done |=> bit_cnt == $past(bit_cnt) + 6'h01)
        else $error("rising edge did not take a bit");
    fall_shift_a: assert property (@(posedge core_clk) disable iff (!nrst)
        out_step |=> serial_out == $past(out_word[WORD_W-1]) && serial_out_oe)
        else $error("falling edge did not present next read bit");
    abort_halt_a: assert property (@(posedge core_clk) disable iff (!nrst)
        busy && abort_s && !prog_start |=> !busy ##1 prog_ready)
        else $error("abort did not stop programming");
    abort_block_a: assert property (@(posedge core_clk) disable iff (!nrst)
        frame_done && abort_s && !busy |=> !busy)
        else $error("write started while abort high");
    latch_gate_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(busy) |-> $past(wel)) else $error("write started with latch clear");
    deselect_a: assert property (@(posedge core_clk) disable iff (!nrst)
        cs_rise |=> state == LINK_IDLE && !serial_out_oe)
        else $error("deselect did not abandon the frame");
    status_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == LINK_STATUS)[*2] |-> serial_out == prog_ready)
        else $error("status output polarity wrong");
    addr_wrap_a: assert property (@(posedge core_clk) disable iff (!nrst)
        word_end && rd_addr == ADDR_TOP |=> rd_addr == '0)
        else $error("read address did not wrap");
    busy_lock_a: assert property (@(posedge core_clk) disable iff (!nrst)
        busy && cs_fall && sck_s && state == LINK_IDLE |=> state == LINK_IGNORE)
        else $error("instruction accepted while busy");
endmodule : eeprom_port

// ---- src/eeprom_port_pkg.sv ----
// Constants shared by the serial word store and its APB register window.
// Assumes a 200 MHz core clock; all link pins arrive asynchronously.
package eeprom_port_pkg;
    // Core clock and self-timed programming time
    localparam int unsigned CORE_PERIOD_NS = 5;
    localparam int unsigned PROG_TIME_NS   = 7000000;
    localparam int unsigned PROG_CYCLES    = PROG_TIME_NS / CORE_PERIOD_NS;

    // Array geometry
    localparam int unsigned ADDR_W    = 10;
    localparam int unsigned WORD_W    = 16;
    localparam int unsigned WORDS     = 1024;
    localparam int unsigned FRAME_W   = 32;
    localparam int unsigned CNT_W     = 6;
    localparam int unsigned PLEN_W    = 24;

    // Frame bit counts
    localparam logic [CNT_W-1:0] HDR_BITS   = 6'h10;
    localparam logic [CNT_W-1:0] FRAME_BITS = 6'h20;

    // Opcode fields
    localparam logic [5:0] OP_WRITE_HI  = 6'h29;
    localparam logic [5:0] OP_READ_HI   = 6'h2a;
    localparam logic [7:0] OP_ENABLE    = 8'ha3;
    localparam logic [7:0] OP_DISABLE   = 8'ha0;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 10'h3ff;

    // APB register byte offsets
    localparam logic [7:0] REG_STATUS    = 8'h00;
    localparam logic [7:0] REG_PROG_LEN  = 8'h04;
    localparam logic [7:0] REG_PEEK_ADDR = 8'h08;
    localparam logic [7:0] REG_PEEK_DATA = 8'h0c;

    // Status register fields
    localparam int unsigned ST_BUSY   = 0;
    localparam int unsigned ST_WEL    = 1;
    localparam int unsigned ST_OE     = 2;
    localparam int unsigned ST_STATE  = 4;

    typedef enum logic [2:0] {
        LINK_IDLE   = 3'b000,
        LINK_RECV   = 3'b001,
        LINK_READ   = 3'b011,
        LINK_STATUS = 3'b010,
        LINK_IGNORE = 3'b110
    } link_state_t;
endpackage : eeprom_port_pkg

// ---- src/pin_sync.sv ----
// Two-flop synchroniser for one asynchronous pin.
// Assumes the pin is a plain level from outside the core clock domain.
`timescale 1ns/10ps
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level
);
    logic first;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            first <= RESET_VAL;
            level <= RESET_VAL;
        end else begin
            first <= pin;
            level <= first;
        end
    end
endmodule : pin_sync

// ---- tb/host_link_model.sv ----
// Host side of the serial link: frames, status probes and the abort pin.
// Assumes core_clk from the bench; the link clock has a 64 ns period, free of core_clk.
`timescale 1ns/10ps
module host_link_model (
    input  wire logic core_clk,
    input  wire logic serial_out,
    input  wire logic serial_out_oe,
    output logic      select_n,
    output logic      shift_clock_in,
    output logic      serial_in_pin,
    output logic      write_abort
);
    initial begin
        select_n       = 1'b1;
        shift_clock_in = 1'b1;
        serial_in_pin  = 1'b0;
        write_abort    = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_n

    task automatic set_abort(input logic v);
        @(posedge core_clk) write_abort <= v;
    endtask : set_abort

    // Shifts n bits MSB first; got holds the driven output before each rise
    task automatic frame(input logic [47:0] bits, input int n, output logic [47:0] got);
        got = '0;
        @(posedge core_clk) select_n <= 1'b0;
        wait_n(8);
        for (int i = n - 1; i >= 0; i--) begin
            shift_clock_in <= 1'b0;
            serial_in_pin  <= bits[i];
            #32;
            got = {got[46:0], serial_out_oe ? serial_out : 1'bz};
            shift_clock_in <= 1'b1;
            #32;
        end
        select_n      <= 1'b1;
        serial_in_pin <= ~serial_in_pin;
        wait_n(60);
    endtask : frame

    task automatic status(output logic v);
        @(posedge core_clk) shift_clock_in <= 1'b0;
        wait_n(3);
        select_n <= 1'b0;
        wait_n(10);
        v = serial_out_oe ? serial_out : 1'bz;
        select_n <= 1'b1;
        wait_n(3);
        shift_clock_in <= 1'b1;
        wait_n(60);
    endtask : status
endmodule : host_link_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the serial word store, with an APB master and a word model.
// Assumes the host link model drives the link pins; no opcode 10101111 is ever built.
`timescale 1ns/10ps
module tb_top;
    import eeprom_port_pkg::*;
    localparam int unsigned PLEN = 200;
    logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        select_n, shift_clock_in, serial_in_pin, write_abort;
    logic        serial_out, serial_out_oe, prog_ready, e, v;
    logic [47:0] got;
    logic [15:0] mem [0:1023];
    logic [9:0]  a;
    logic [15:0] d;
    int          errors, total_checks, cycles, low_run, last_low, plen;

    eeprom_port #(.PROG_LEN_DEFAULT(PLEN)) eeprom_port_inst (
        .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .select_n(select_n),
        .shift_clock_in(shift_clock_in), .serial_in_pin(serial_in_pin),
        .write_abort(write_abort), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .prog_ready(prog_ready));

    host_link_model host_link_model_inst (
        .core_clk(core_clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .select_n(select_n), .shift_clock_in(shift_clock_in),
        .serial_in_pin(serial_in_pin), .write_abort(write_abort));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Length of the last busy run and a hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (prog_ready === 1'b0) low_run <= low_run + 1;
        else if (low_run != 0) begin
            last_low <= low_run;
            low_run  <= 0;
        end
        if (cycles == 60000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic peek(input logic [9:0] pa);
        apb(1'b1, REG_PEEK_ADDR, {22'h0, pa});
        apb(1'b0, REG_PEEK_DATA, 32'h0);
        chk(r, {16'h0, mem[pa]}, "word");
    endtask : peek

    task automatic wait_ready();
        for (int k = 0; k < 4000 && prog_ready !== 1'b1; k++) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        chk(prog_ready, 1'b1, "ready");
    endtask : wait_ready

    task automatic cmd(input logic [7:0] op);
        host_link_model_inst.frame({32'h0, op, 8'h5a}, 16, got);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(r[ST_WEL], op == OP_ENABLE, "latch");
    endtask : cmd

    task automatic lwrite(input logic [9:0] wa, input logic [15:0] wd, input logic prog);
        host_link_model_inst.frame({16'h0, OP_WRITE_HI, wa, wd}, 32, got);
        chk(prog_ready, !prog, "busy start");
        wait_ready();
        if (prog) begin
            mem[wa] = wd;
            chk(last_low, plen, "busy length");
        end
    endtask : lwrite

    task automatic lread(input logic [9:0] ra);
        logic [9:0] nx;
        nx = ra + 10'h1;
        host_link_model_inst.frame({OP_READ_HI, ra, 32'h0}, 48, got);
        chk(got[31:0], {mem[ra], mem[nx]}, "read");
        chk(serial_out_oe, 1'b0, "released");
    endtask : lread

    initial begin
        void'($urandom(32'h8d7b));
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        errors = 0;
        total_checks = 0;
        cycles = 0;
        low_run = 0;
        last_low = 0;
        plen = PLEN;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk({prog_ready, serial_out_oe}, 2'b10, "idle pins");
        apb(1'b0, REG_PROG_LEN, 32'h0);
        chk(r, PLEN, "length reset");
        apb(1'b1, 8'h10, 32'hffff_ffff);
        chk(e, 1'b1, "unmapped error");
        chk(r, 32'h0, "unmapped data");
        chk(pready, 1'b1, "bus ready");
        apb(1'b0, REG_STATUS, 32'h0);
        chk(r, 32'h0, "status reset");
        $display("test reset done");

        lwrite(ADDR_TOP, 16'h1234, 1'b0);
        cmd(OP_ENABLE);
        lwrite(ADDR_TOP, 16'hc3a5, 1'b1);
        lwrite(10'h0, 16'h5a3c, 1'b1);
        for (int i = 0; i < 3; i++) begin
            a = 10'($urandom);
            d = 16'($urandom);
            lwrite(a, d, 1'b1);
            peek(a);
        end
        lwrite(a + 10'h1, ~d, 1'b1);
        lread(ADDR_TOP);
        cmd(OP_DISABLE);
        lread(a);
        host_link_model_inst.frame({24'h0, OP_READ_HI, a, 8'h00}, 24, got);
        chk(got[7:0], mem[a][15:8], "short read");
        chk(serial_out_oe, 1'b0, "abandoned");
        $display("test write and read done");

        cmd(OP_ENABLE);
        apb(1'b1, REG_PROG_LEN, 32'h5dc);
        plen = 1500;
        host_link_model_inst.frame({16'h0, OP_WRITE_HI, 10'h155, 16'h0f0f}, 32, got);
        host_link_model_inst.status(v);
        chk(v, 1'b0, "status busy");
        host_link_model_inst.frame({16'h0, OP_WRITE_HI, 10'h2aa, 16'h1111}, 32, got);
        mem[10'h155] = 16'h0f0f;
        wait_ready();
        chk(last_low, plen, "long busy");
        peek(10'h155);
        peek(10'h2aa);
        host_link_model_inst.status(v);
        chk(v, 1'b1, "status ready");
        apb(1'b1, REG_PROG_LEN, PLEN);
        plen = PLEN;
        $display("test busy done");

        host_link_model_inst.set_abort(1'b1);
        cmd(OP_DISABLE);
        cmd(OP_ENABLE);
        lwrite(ADDR_TOP, 16'hdead, 1'b0);
        lread(ADDR_TOP);
        host_link_model_inst.set_abort(1'b0);
        host_link_model_inst.frame({16'h0, OP_WRITE_HI, ADDR_TOP, 16'h7777}, 32, got);
        host_link_model_inst.set_abort(1'b1);
        repeat (8) @(posedge core_clk);
        chk(prog_ready, 1'b1, "aborted");
        host_link_model_inst.set_abort(1'b0);
        peek(ADDR_TOP);
        lwrite(ADDR_TOP, 16'h8001, 1'b1);
        peek(ADDR_TOP);
        $display("test abort done");
        print_verdict();
    end
endmodule : tb_top
